/* File: core/hot_swap_status_registers.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Hot swap status bytes with read-byte command port.
//==========================================================================
module hot_swap_status_registers
    import status_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Read-byte command port from the bus engine.
    input  wire logic       rd_req,
    input  wire logic [7:0] rd_cmd,
    output logic [7:0]      rd_data_ff,
    output logic            rd_valid_ff,
    output logic            rd_unsupported_ff,
    // Clear request for all latched status.
    input  wire logic       clear_faults,
    // Power monitor events.
    input  wire logic       output_overvoltage_warning,
    input  wire logic       output_undervoltage_warning,
    input  wire logic       output_overcurrent_warning,
    input  wire logic       input_overvoltage_warning,
    input  wire logic       input_undervoltage_warning,
    input  wire logic       input_overpower_warning,
    input  wire logic       second_current_over,
    input  wire logic       second_current_under,
    input  wire logic       second_warning_polarity_select,
    // Protection events.
    input  wire logic       timed_overcurrent_fault,
    input  wire logic       gate_shut_down,
    input  wire logic       active_current_limiting,
    input  wire logic       pass_switch_suspect_short,
    input  wire logic       under_threshold_comparator_live,
    input  wire logic       over_threshold_comparator_live,
    input  wire logic       host_turn_on,
    // Summary flags for the status word.
    output logic [3:0]      summary_ff
);
    //======================================================================
    // Event gathering.
    //======================================================================
    logic [7:0] vout_set;
    logic [7:0] iout_set;
    logic [7:0] input_set;
    logic [7:0] vendor_set;
    logic [7:0] clr_all;
    logic [7:0] vout_ff;
    logic [7:0] iout_ff;
    logic [7:0] input_ff;
    logic [7:0] vendor_ff;
    logic       oc_shutdown;
    logic       warn2_hit;
    cause_t     cause_ff;
    logic [7:0] vendor_byte;
    logic [7:0] nxt_rd_data;
    logic       nxt_unsupported;

    // One clear level reaches every bit of every bank.
    assign clr_all = {8{clear_faults}};
    assign oc_shutdown = timed_overcurrent_fault & gate_shut_down;
    assign warn2_hit = second_warning_polarity_select ?
                       second_current_under : second_current_over;

    // Reserved positions stay zero because no set line feeds them.
    always_comb begin
        vout_set = 8'h00;
        iout_set = 8'h00;
        input_set = 8'h00;
        vendor_set = 8'h00;
        vout_set[BIT_VOUT_OV] = output_overvoltage_warning;
        vout_set[BIT_VOUT_UV] = output_undervoltage_warning;
        iout_set[BIT_TIMED_OVERCURRENT_FAULT] = oc_shutdown;
        iout_set[BIT_OUTPUT_OVERCURRENT_WARNING] = output_overcurrent_warning;
        input_set[BIT_INPUT_OVERVOLTAGE_PIN_FAULT] = over_threshold_comparator_live;
        input_set[BIT_INPUT_OVERVOLTAGE_WARNING] = input_overvoltage_warning;
        input_set[BIT_INPUT_UNDERVOLTAGE_WARNING] = input_undervoltage_warning;
        input_set[BIT_INPUT_UNDERVOLTAGE_PIN_FAULT] = under_threshold_comparator_live;
        input_set[BIT_PIN_OP] = input_overpower_warning;
        vendor_set[BIT_SWITCH_SHORT] = pass_switch_suspect_short;
        vendor_set[BIT_INLIM] = active_current_limiting;
        vendor_set[BIT_WARN2] = warn2_hit;
    end

    //======================================================================
    // Latched flag banks.
    //======================================================================
    sticky_flags #(.WIDTH(8)) u_vout (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (vout_set),
        .clr_in   (clr_all),
        .flags_ff (vout_ff)
    );
    sticky_flags #(.WIDTH(8)) u_iout (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (iout_set),
        .clr_in   (clr_all),
        .flags_ff (iout_ff)
    );
    sticky_flags #(.WIDTH(8)) u_input (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (input_set),
        .clr_in   (clr_all),
        .flags_ff (input_ff)
    );
    sticky_flags #(.WIDTH(8)) u_vendor (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .set_in   (vendor_set),
        .clr_in   (clr_all),
        .flags_ff (vendor_ff)
    );
    cause_latch u_cause (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .oc_shutdown  (oc_shutdown),
        .uv_shutdown  (under_threshold_comparator_live & gate_shut_down),
        .ov_shutdown  (over_threshold_comparator_live & gate_shut_down),
        .host_turn_on (host_turn_on),
        .clr          (clear_faults),
        .cause_ff     (cause_ff)
    );

    // Live comparator bits and cause merge into the latched vendor bits.
    always_comb begin
        vendor_byte = vendor_ff;
        vendor_byte[BIT_UV_LIVE] = under_threshold_comparator_live;
        vendor_byte[BIT_OV_LIVE] = over_threshold_comparator_live;
        vendor_byte[2:1] = cause_ff;
    end

    //======================================================================
    // Read-byte decode.
    //======================================================================
    // Unknown codes return zero and flag the access for the bus engine.
    always_comb begin
        nxt_rd_data = STATUS_RESET;
        nxt_unsupported = 1'b0;
        if (rd_cmd == CMD_VOUT_STATUS) begin
            nxt_rd_data = vout_ff;
        end else if (rd_cmd == CMD_IOUT_STATUS) begin
            nxt_rd_data = iout_ff;
        end else if (rd_cmd == CMD_INPUT_STATUS) begin
            nxt_rd_data = input_ff;
        end else if (rd_cmd == CMD_VENDOR_STATUS) begin
            nxt_rd_data = vendor_byte;
        end else begin
            nxt_unsupported = 1'b1;
        end
    end

    // Answer registered one cycle after the request.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data_ff <= STATUS_RESET;
            rd_valid_ff <= 1'b0;
            rd_unsupported_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_req;
            if (rd_req) begin
                rd_data_ff <= nxt_rd_data;
                rd_unsupported_ff <= nxt_unsupported;
            end
        end
    end

    // Summary flags follow the bytes one cycle late.
    // summary per byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            summary_ff <= 4'h0;
        end else begin
            summary_ff <= {|vout_ff, |iout_ff, |input_ff, |vendor_byte};
        end
    end

    //======================================================================
    // Checks.
    //======================================================================
    // reserved bits zero
    chk_vout_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd == CMD_VOUT_STATUS) |=>
        (rd_valid_ff && rd_data_ff[7] == 1'b0 && rd_data_ff[4:0] == 5'h00))
        else $error("output voltage byte reserved bits set");

    chk_vout_ov: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        output_overvoltage_warning |=> vout_ff[BIT_VOUT_OV])
        else $error("output overvoltage not latched");

    chk_vout_uv: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        output_undervoltage_warning |=> vout_ff[BIT_VOUT_UV])
        else $error("output undervoltage not latched");

    chk_iout_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd == CMD_IOUT_STATUS) |=>
        (rd_data_ff[6] == 1'b0 && rd_data_ff[4:0] == 5'h00))
        else $error("output current reserved bits set");

    chk_oc_fault: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!iout_ff[BIT_TIMED_OVERCURRENT_FAULT] && !gate_shut_down)
        |=> !iout_ff[BIT_TIMED_OVERCURRENT_FAULT])
        else $error("overcurrent fault without shutdown");

    chk_oc_latch: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        oc_shutdown |=> iout_ff[BIT_TIMED_OVERCURRENT_FAULT])
        else $error("timed overcurrent fault not latched");

    chk_oc_warn: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        output_overcurrent_warning |=> iout_ff[BIT_OUTPUT_OVERCURRENT_WARNING])
        else $error("overcurrent warning not latched");

    chk_input_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd == CMD_INPUT_STATUS) |=> rd_data_ff[3:1] == 3'h0)
        else $error("input byte reserved bits set");

    chk_vin_ovpin: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        over_threshold_comparator_live |=> input_ff[BIT_INPUT_OVERVOLTAGE_PIN_FAULT])
        else $error("overvoltage pin fault not latched");

    chk_vin_warn: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (input_overvoltage_warning && input_undervoltage_warning)
        |=> (input_ff[BIT_INPUT_OVERVOLTAGE_WARNING] && input_ff[BIT_INPUT_UNDERVOLTAGE_WARNING]))
        else $error("input warnings not latched");

    chk_vin_uvpin: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        under_threshold_comparator_live |=> input_ff[BIT_INPUT_UNDERVOLTAGE_PIN_FAULT])
        else $error("undervoltage pin fault not latched");

    chk_overpower: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        input_overpower_warning |=> input_ff[BIT_PIN_OP])
        else $error("overpower not latched");

    chk_vendor_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd == CMD_VENDOR_STATUS) |=> rd_data_ff[4] == 1'b0)
        else $error("vendor reserved bit set");

    chk_switch_short: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        pass_switch_suspect_short |=> vendor_ff[BIT_SWITCH_SHORT])
        else $error("switch short not latched");

    chk_live_cmp: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd == CMD_VENDOR_STATUS) |=>
        (rd_data_ff[6] == $past(under_threshold_comparator_live)
         && rd_data_ff[5] == $past(over_threshold_comparator_live)))
        else $error("live comparator bits wrong");

    chk_inlim: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        active_current_limiting |=> vendor_ff[BIT_INLIM])
        else $error("current limiting not latched at once");

    chk_cause_uv: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (under_threshold_comparator_live && gate_shut_down
         && !over_threshold_comparator_live) |=> cause_ff == CAUSE_UV)
        else $error("undervoltage cause not recorded");

    chk_cause_oc: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (oc_shutdown && !under_threshold_comparator_live
         && !over_threshold_comparator_live) |=> cause_ff == CAUSE_OC)
        else $error("overcurrent cause not recorded");

    chk_warn2: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (second_warning_polarity_select && second_current_under)
        |=> vendor_ff[BIT_WARN2])
        else $error("second warning not latched");

    chk_warn2_over: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (!second_warning_polarity_select && second_current_over)
        |=> vendor_ff[BIT_WARN2])
        else $error("second overcurrent warning not latched");

    chk_summary: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> summary_ff == {|$past(vout_ff), |$past(iout_ff),
                                |$past(input_ff), |$past(vendor_byte)})
        else $error("summary flag wrong");

    chk_clear_vout: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (clear_faults && !output_overvoltage_warning
         && !output_undervoltage_warning) |=> vout_ff == STATUS_RESET)
        else $error("output voltage flags survived clear");

    chk_reset_zero: assert property (
        @(posedge clk_sys)
        !rst_n |=> (vout_ff == STATUS_RESET && iout_ff == STATUS_RESET
                    && input_ff == STATUS_RESET && vendor_ff == STATUS_RESET
                    && cause_ff == CAUSE_NONE))
        else $error("latched status survived reset");

    chk_unknown_cmd: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_req && rd_cmd != CMD_VOUT_STATUS && rd_cmd != CMD_IOUT_STATUS
         && rd_cmd != CMD_INPUT_STATUS && rd_cmd != CMD_VENDOR_STATUS)
        |=> (rd_unsupported_ff && rd_data_ff == STATUS_RESET))
        else $error("unknown code not refused");
endmodule : hot_swap_status_registers
`default_nettype wire

/* File: core/status_pkg.sv */
//==========================================================================
// Status byte constants.
//==========================================================================
package status_pkg;
    localparam logic [7:0] CMD_VOUT_STATUS = 8'h7A;
    localparam logic [7:0] CMD_IOUT_STATUS = 8'h7B;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
    localparam logic [7:0] CMD_VENDOR_STATUS = 8'h80;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int BIT_VOUT_OV = 6;
    localparam int BIT_VOUT_UV = 5;
    localparam int BIT_TIMED_OVERCURRENT_FAULT = 7;
    localparam int BIT_OUTPUT_OVERCURRENT_WARNING = 5;
    localparam int BIT_INPUT_OVERVOLTAGE_PIN_FAULT = 7;
    localparam int BIT_INPUT_OVERVOLTAGE_WARNING = 6;
    localparam int BIT_INPUT_UNDERVOLTAGE_WARNING = 5;
    localparam int BIT_INPUT_UNDERVOLTAGE_PIN_FAULT = 4;
    localparam int BIT_PIN_OP = 0;
    localparam int BIT_SWITCH_SHORT = 7;
    localparam int BIT_UV_LIVE = 6;
    localparam int BIT_OV_LIVE = 5;
    localparam int BIT_INLIM = 3;
    localparam int BIT_WARN2 = 0;
    typedef enum logic [1:0] {
        CAUSE_NONE = 2'b00,
        CAUSE_OC   = 2'b01,
        CAUSE_UV   = 2'b10,
        CAUSE_OV   = 2'b11
    } cause_t;
endpackage : status_pkg

/* File: core/sticky_flags.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Bank of sticky flags; a set in the clear cycle wins.
//==========================================================================
module sticky_flags
    import status_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output logic      [WIDTH-1:0] flags_ff
);
    // Flags hold until cleared, set taking priority over clear.
    // hold until clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (flags_ff & ~clr_in) | set_in;
        end
    end

    chk_flag_holds: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> ((flags_ff & $past(flags_ff) & ~$past(clr_in))
                  == ($past(flags_ff) & ~$past(clr_in))))
        else $error("sticky flag dropped without clear");
endmodule : sticky_flags
`default_nettype wire

/* File: core/cause_latch.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Shutdown cause latch.
//==========================================================================
module cause_latch
    import status_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic oc_shutdown,
    input  wire logic uv_shutdown,
    input  wire logic ov_shutdown,
    input  wire logic host_turn_on,
    input  wire logic clr,
    output cause_t    cause_ff
);
    // The newest fault overwrites the code; a host turn-on or clear
    // returns to normal. Overvoltage wins when several hit together.
    // cause code latch
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cause_ff <= CAUSE_NONE;
        end else if (ov_shutdown) begin
            cause_ff <= CAUSE_OV;
        end else if (uv_shutdown) begin
            cause_ff <= CAUSE_UV;
        end else if (oc_shutdown) begin
            cause_ff <= CAUSE_OC;
        end else if (host_turn_on || clr) begin
            cause_ff <= CAUSE_NONE;
        end
    end

    chk_cause_ov: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ov_shutdown |=> cause_ff == CAUSE_OV)
        else $error("overvoltage cause not recorded");
    chk_cause_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (host_turn_on && !ov_shutdown && !uv_shutdown && !oc_shutdown)
        |=> cause_ff == CAUSE_NONE)
        else $error("cause not returned to normal");
endmodule : cause_latch
`default_nettype wire

/* File: test/status_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Bus engine stand-in that issues read-byte requests to the status bank.
//==========================================================================
module status_reader_model (
    input  wire logic       clk_sys,
    output var  logic       rd_req,
    output var  logic [7:0] rd_cmd,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire logic       rd_unsupported
);
    // The idle command bus carries a defined value from time zero.
    initial begin
        rd_req = 1'b0;
        rd_cmd = 8'h00;
    end

    // single read-byte
    // One request pulse per byte; the answer is taken one edge later and the
    // valid pulse must be gone on the edge after that.
    task automatic read_byte(input  logic [7:0] cmd,
                             output logic [7:0] data,
                             output logic       unsup,
                             output logic       ok);
        @(posedge clk_sys);
        rd_req <= 1'b1;
        rd_cmd <= cmd;
        @(posedge clk_sys);
        rd_req <= 1'b0;
        // Inverted code after release, so a stale sample cannot pass.
        rd_cmd <= ~cmd;
        @(posedge clk_sys);
        ok    = (rd_valid === 1'b1);
        data  = rd_data;
        unsup = rd_unsupported;
        @(posedge clk_sys);
        ok = ok && (rd_valid === 1'b0);
    endtask : read_byte
endmodule : status_reader_model
`default_nettype wire

/* File: test/hot_swap_status_registers_tb.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Self-checking bench for the hot swap status bytes.
//==========================================================================
module hot_swap_status_registers_tb;
    import status_pkg::*;

    localparam int LIMIT = 3000;

    logic        clk_sys;
    logic        rst_n;
    logic [16:0] ev;
    logic        rd_req;
    logic [7:0]  rd_cmd;
    logic [7:0]  rd_data_ff;
    logic        rd_valid_ff;
    logic        rd_unsupported_ff;
    logic [3:0]  summary_ff;
    int          errors;
    int          comparisons;
    int          cycles;

    // Event bits: 0 out ov, 1 out uv, 2 oc warn, 3 in ov, 4 in uv, 5 power,
    // 6 warn2 over, 7 warn2 under, 8 select, 9 timed oc, 10 gate off,
    // 11 limiting, 12 short, 13 uv cmp, 14 ov cmp, 15 host on, 16 clear.
    hot_swap_status_registers i_dut (
        .clk_sys                         (clk_sys),
        .rst_n                           (rst_n),
        .rd_req                          (rd_req),
        .rd_cmd                          (rd_cmd),
        .rd_data_ff                      (rd_data_ff),
        .rd_valid_ff                     (rd_valid_ff),
        .rd_unsupported_ff               (rd_unsupported_ff),
        .clear_faults                    (ev[16]),
        .output_overvoltage_warning      (ev[0]),
        .output_undervoltage_warning     (ev[1]),
        .output_overcurrent_warning      (ev[2]),
        .input_overvoltage_warning       (ev[3]),
        .input_undervoltage_warning      (ev[4]),
        .input_overpower_warning         (ev[5]),
        .second_current_over             (ev[6]),
        .second_current_under            (ev[7]),
        .second_warning_polarity_select  (ev[8]),
        .timed_overcurrent_fault         (ev[9]),
        .gate_shut_down                  (ev[10]),
        .active_current_limiting         (ev[11]),
        .pass_switch_suspect_short       (ev[12]),
        .under_threshold_comparator_live (ev[13]),
        .over_threshold_comparator_live  (ev[14]),
        .host_turn_on                    (ev[15]),
        .summary_ff                      (summary_ff)
    );

    status_reader_model i_host (
        .clk_sys        (clk_sys),
        .rd_req         (rd_req),
        .rd_cmd         (rd_cmd),
        .rd_data        (rd_data_ff),
        .rd_valid       (rd_valid_ff),
        .rd_unsupported (rd_unsupported_ff)
    );

    // Free-running 250 MHz clock.
    always #2 clk_sys = ~clk_sys;

    // Cycle ceiling, so a hung handshake still reaches the report.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors = errors + 1;
            close_out();
        end
    end

    //======================================================================
    // Shared tasks.
    //======================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at time %0h: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Events change one edge and are held across the next latching edge.
    task automatic apply(input logic [16:0] val);
        @(posedge clk_sys);
        ev <= val;
        @(posedge clk_sys);
    endtask : apply

    task automatic expect_rd(input logic [7:0] cmd, input logic [7:0] exp,
                             input logic exp_unsup);
        logic [7:0] data;
        logic       unsup;
        logic       ok;
        i_host.read_byte(cmd, data, unsup, ok);
        check(data, exp); // answer byte
        check({7'h00, unsup}, {7'h00, exp_unsup}); // unsupported flag
        check({7'h00, ok}, 8'h01); // one valid pulse
    endtask : expect_rd

    task automatic clear_all();
        apply(17'h1_0000);
        apply(17'h0_0000);
    endtask : clear_all

    //======================================================================
    // Scenarios.
    //======================================================================
    task automatic reset_values();
        expect_rd(CMD_VOUT_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_IOUT_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_INPUT_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        check({4'h0, summary_ff}, 8'h00);
        // The word code is outside this bank, so it must be refused.
        expect_rd(8'h79, 8'h00, 1'b1);
    endtask : reset_values

    task automatic output_voltage();
        apply(17'h0_0001);
        apply(17'h0_0000);
        expect_rd(CMD_VOUT_STATUS, 8'h40, 1'b0);
        apply(17'h0_0002);
        apply(17'h0_0000);
        expect_rd(CMD_VOUT_STATUS, 8'h60, 1'b0);
        check({4'h0, summary_ff}, 8'h08);
        clear_all();
        expect_rd(CMD_VOUT_STATUS, 8'h00, 1'b0);
        check({4'h0, summary_ff}, 8'h00);
    endtask : output_voltage

    task automatic output_current();
        apply(17'h0_0004);
        apply(17'h0_0200);
        apply(17'h0_0000);
        // Timer expiry alone, with the gate still on, must not latch.
        expect_rd(CMD_IOUT_STATUS, 8'h20, 1'b0);
        apply(17'h0_0600);
        apply(17'h0_0000);
        expect_rd(CMD_IOUT_STATUS, 8'hA0, 1'b0);
        expect_rd(CMD_VENDOR_STATUS, 8'h02, 1'b0);
        check({4'h0, summary_ff}, 8'h05);
        apply(17'h0_8000);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_IOUT_STATUS, 8'hA0, 1'b0);
        clear_all();
        expect_rd(CMD_IOUT_STATUS, 8'h00, 1'b0);
    endtask : output_current

    task automatic input_supply();
        apply(17'h0_0038);
        apply(17'h0_0000);
        expect_rd(CMD_INPUT_STATUS, 8'h61, 1'b0);
        apply(17'h0_4000);
        expect_rd(CMD_INPUT_STATUS, 8'hE1, 1'b0);
        expect_rd(CMD_VENDOR_STATUS, 8'h20, 1'b0);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_INPUT_STATUS, 8'hE1, 1'b0);
        apply(17'h0_2000);
        expect_rd(CMD_INPUT_STATUS, 8'hF1, 1'b0);
        expect_rd(CMD_VENDOR_STATUS, 8'h40, 1'b0);
        check({4'h0, summary_ff}, 8'h03);
        apply(17'h0_2400);
        expect_rd(CMD_VENDOR_STATUS, 8'h44, 1'b0);
        apply(17'h0_6400);
        expect_rd(CMD_VENDOR_STATUS, 8'h66, 1'b0);
        apply(17'h0_0000);
        clear_all();
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_INPUT_STATUS, 8'h00, 1'b0);
    endtask : input_supply

    task automatic vendor_bits();
        apply(17'h0_1800);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h88, 1'b0);
        apply(17'h0_0080);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h88, 1'b0);
        apply(17'h0_0040);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h89, 1'b0);
        clear_all();
        apply(17'h0_0140);
        apply(17'h0_0100);
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        apply(17'h0_0180);
        apply(17'h0_0000);
        expect_rd(CMD_VENDOR_STATUS, 8'h01, 1'b0);
        clear_all();
    endtask : vendor_bits

    // A reset in mid-run must drop every latched flag.
    task automatic reset_clears();
        apply(17'h0_1001);
        apply(17'h0_0000);
        expect_rd(CMD_VOUT_STATUS, 8'h40, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        expect_rd(CMD_VOUT_STATUS, 8'h00, 1'b0);
        expect_rd(CMD_VENDOR_STATUS, 8'h00, 1'b0);
        check({4'h0, summary_ff}, 8'h00);
    endtask : reset_clears

    //======================================================================
    // Report and main sequence.
    //======================================================================
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // Reset is held for 20 edges before any request is made.
    initial begin
        clk_sys     = 1'b0;
        rst_n       = 1'b0;
        ev          = 17'h0_0000;
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        reset_values();
        output_voltage();
        output_current();
        input_supply();
        vendor_bits();
        reset_clears();
        close_out();
    end
endmodule : hot_swap_status_registers_tb
`default_nettype wire
